// File: logic/gpab_defs.vh
// gpab_defs.vh: offsets, implemented-bit masks, reset values for the four-port gpio block
// assumes: included by the gpio design files; definitions only
//
// Summary of operation
// - unimplemented register bits read zero and ignore writes
// - 64-pin variant: port a absent entirely, all its registers read zero
// - 64-pin variant: port c bits 1..4 and port d bits 12..15 absent
// - port c bits 12 and 15 usable only when oscillator mode is 11 or 00
// - port c bit 15 also needs the oscillator output function bit set
// - direction resets: a C6FF, b FFFF, c F01E, d FFFF
// - open-drain registers reset to 0000; pin and latch have no defined reset (the latch resets to 0000 here)
`ifndef GPAB_DEFS_VH
`define GPAB_DEFS_VH

// register indices; printed offsets are even but not all multiples of four, so index*4
`define GPAB_IDX_BASE         16'h02C0
`define GPAB_IDX_A_DIR        16'h02C0
`define GPAB_IDX_A_PINS       16'h02C2
`define GPAB_IDX_A_LAT        16'h02C4
`define GPAB_IDX_A_ODC        16'h02C6
`define GPAB_IDX_B_DIR        16'h02C8
`define GPAB_IDX_B_PINS       16'h02CA
`define GPAB_IDX_B_LAT        16'h02CC
`define GPAB_IDX_B_ODC        16'h02CE
`define GPAB_IDX_C_DIR        16'h02D0
`define GPAB_IDX_C_PINS       16'h02D2
`define GPAB_IDX_C_LAT        16'h02D4
`define GPAB_IDX_C_ODC        16'h02D6
`define GPAB_IDX_D_DIR        16'h02D8
`define GPAB_IDX_D_PINS       16'h02DA
`define GPAB_IDX_D_LAT        16'h02DC
`define GPAB_IDX_D_ODC        16'h02DE
// register slots within a port (index step 2 per register, 8 per port)
`define GPAB_SLOT_DIR         2'h0
`define GPAB_SLOT_PINS        2'h1
`define GPAB_SLOT_LAT         2'h2
`define GPAB_SLOT_ODC         2'h3

// implemented bits, 100-pin variant
`define GPAB_MASK_A           16'hC6FF
`define GPAB_MASK_B           16'hFFFF
`define GPAB_MASK_C           16'hF01E
`define GPAB_MASK_D           16'hFFFF
// bits removed in the 64-pin variant
`define GPAB_CUT64_A          16'hFFFF
`define GPAB_CUT64_C          16'h001E
`define GPAB_CUT64_D          16'hF000
// port c oscillator-shared bits
`define GPAB_C_BIT_TWELVE     12
`define GPAB_C_BIT_FIFTEEN    15
`define GPAB_OSC_OFF          2'h3
`define GPAB_OSC_EXT_CLOCK    2'h0

// reset values
`define GPAB_RST_A_DIR        16'hC6FF
`define GPAB_RST_B_DIR        16'hFFFF
`define GPAB_RST_C_DIR        16'hF01E
`define GPAB_RST_D_DIR        16'hFFFF
`define GPAB_RST_ODC          16'h0000
`define GPAB_RST_DATA         16'h0000

`endif

// File: logic/gpab_sync.v
// gpab_sync.v: two-flop synchroniser for a bus of pin inputs
// assumes: inputs are asynchronous to ref_clk
`timescale 1ns/100ps
module gpab_sync #(
    parameter WIDTH = 16
) (
    input  wire             ref_clk,
    input  wire             rst,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;

    // first stage is read only by the second stage
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// File: logic/gpab_port.v
// gpab_port.v: one 16-bit gpio port: direction, latch, open-drain, pin sampling
// assumes: imp_mask is static (tied from configuration); writes come from the bus slave
`timescale 1ns/100ps
`include "gpab_defs.vh"
module gpab_port #(
    parameter [15:0] DIR_RESET = 16'hFFFF
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [15:0] imp_mask,
    input  wire        wr_en,
    input  wire [1:0]  wr_slot,
    input  wire [15:0] wr_data,
    input  wire [15:0] pin_in,
    output wire [15:0] pin_out,
    output wire [15:0] pin_oe,
    output reg  [15:0] direction,
    output reg  [15:0] output_latch,
    output reg  [15:0] open_drain,
    output wire [15:0] pin_state
);
    wire [15:0] pin_sync;

    gpab_sync #(.WIDTH(16)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // writes to the pins slot land in the latch, as on the usual port model
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            direction    <= DIR_RESET & `GPAB_MASK_D;
            open_drain   <= `GPAB_RST_ODC;
            output_latch <= `GPAB_RST_DATA;             // undefined in hardware; zero here
        end else if (wr_en) begin
            if (wr_slot == `GPAB_SLOT_DIR) begin
                direction <= (wr_data & imp_mask) | (direction & ~imp_mask);
            end else if (wr_slot == `GPAB_SLOT_ODC) begin
                open_drain <= wr_data & imp_mask;
            end else begin
                output_latch <= wr_data & imp_mask;
            end
        end
    end

    // inputs read from the pad; absent bits read zero
    assign pin_state = pin_sync & imp_mask;
    // open-drain only pulls low, so drive enable is the inverse of the latch when the od bit is set
    assign pin_out   = output_latch & ~open_drain;
    assign pin_oe    = ~direction & imp_mask & ~(open_drain & output_latch);
endmodule

// File: logic/gpab_top.v
// gpab_top.v: four gpio ports a..d behind an ahb-lite slave
// assumes: single ahb-lite master, word transfers; oscillator config bits are static straps
`timescale 1ns/100ps
`include "gpab_defs.vh"
module gpab_top #(
    parameter PINS_100 = 1
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire [1:0]  primary_osc_mode_field,
    input  wire        osc_output_function_bit,
    input  wire [63:0] pad_in,
    output wire [63:0] pad_out,
    output wire [63:0] pad_oe
);
    reg  [1:0]  osc_mode;
    reg         osc_fn;
    reg         cfg_loaded;
    reg  [15:0] mask_c_cfg;
    wire [15:0] mask_a;
    wire [15:0] mask_c;
    wire [15:0] mask_d;
    wire [63:0] imp_mask;
    wire [63:0] dir_all;
    wire [63:0] lat_all;
    wire [63:0] odc_all;
    wire [63:0] pin_all;
    reg         wr_pend;
    reg  [15:0] wr_addr;
    wire [15:0] byte_off;
    wire        in_range;
    wire [1:0]  sel_port;
    wire [1:0]  sel_slot;
    reg  [15:0] rd_word;

    // configuration straps are caught after reset release; async reset takes constants only
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_mode   <= 2'h1;
            osc_fn     <= 1'b0;
            cfg_loaded <= 1'b0;
        end else if (!cfg_loaded) begin
            osc_mode   <= primary_osc_mode_field;
            osc_fn     <= osc_output_function_bit;
            cfg_loaded <= 1'b1;
        end
    end

    // oscillator pins take bits 12 and 15 of port c away
    always @* begin
        mask_c_cfg = `GPAB_MASK_C;
        if (!(osc_mode == `GPAB_OSC_OFF || osc_mode == `GPAB_OSC_EXT_CLOCK)) begin
            mask_c_cfg[`GPAB_C_BIT_TWELVE] = 1'b0;
            mask_c_cfg[`GPAB_C_BIT_FIFTEEN] = 1'b0;
        end
        if (!osc_fn) begin
            mask_c_cfg[`GPAB_C_BIT_FIFTEEN] = 1'b0;
        end
    end

    // package variant trims whole port a and the edge bits of c and d
    assign mask_a = (PINS_100 != 0) ? `GPAB_MASK_A : 16'h0000;
    assign mask_c = (PINS_100 != 0) ? mask_c_cfg : (mask_c_cfg & ~`GPAB_CUT64_C);
    assign mask_d = (PINS_100 != 0) ? `GPAB_MASK_D : (`GPAB_MASK_D & ~`GPAB_CUT64_D);
    assign imp_mask = {mask_d, mask_c, `GPAB_MASK_B, mask_a};

    // ahb-lite: latch the write address phase, commit during the data phase
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_pend <= 1'b0;
            wr_addr <= 16'h0000;
        end else if (hready) begin
            wr_pend <= hsel & htrans[1] & hwrite & (haddr[31:16] == 16'h0000);
            wr_addr <= haddr[15:0];
        end
    end

    // read data registered at the address phase so it stands in the data phase
    // byte address is four times the register index, so registers sit eight bytes apart
    assign byte_off = haddr[15:0] - (`GPAB_IDX_BASE << 2);
    assign in_range = (haddr[31:16] == 16'h0000) && (haddr[2:0] == 3'h0)
                      && (haddr[15:0] >= (`GPAB_IDX_BASE << 2))
                      && (haddr[15:0] <= (`GPAB_IDX_D_ODC << 2));
    assign sel_port = byte_off[6:5];
    assign sel_slot = byte_off[4:3];

    // reads are masked: direction keeps reset ones in absent bits, and straps may remove bits later
    always @* begin
        rd_word = 16'h0000;
        if (in_range) begin
            if (sel_slot == `GPAB_SLOT_DIR) begin
                rd_word = dir_all[sel_port*16 +: 16] & imp_mask[sel_port*16 +: 16];
            end else if (sel_slot == `GPAB_SLOT_PINS) begin
                rd_word = pin_all[sel_port*16 +: 16] & imp_mask[sel_port*16 +: 16];
            end else if (sel_slot == `GPAB_SLOT_LAT) begin
                rd_word = lat_all[sel_port*16 +: 16] & imp_mask[sel_port*16 +: 16];
            end else begin
                rd_word = odc_all[sel_port*16 +: 16] & imp_mask[sel_port*16 +: 16];
            end
        end
    end

    // unmapped addresses read zero and ignore writes, always OKAY
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= {16'h0000, rd_word};
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // write decode for the pending data phase
    wire [15:0] wr_off = wr_addr - (`GPAB_IDX_BASE << 2);
    wire        wr_ok  = wr_pend && (wr_addr[2:0] == 3'h0)
                         && (wr_addr >= (`GPAB_IDX_BASE << 2))
                         && (wr_addr <= (`GPAB_IDX_D_ODC << 2));

    // one port instance per port, reset direction per port
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            localparam [15:0] DIRR = (p == 0) ? `GPAB_RST_A_DIR : (p == 1) ? `GPAB_RST_B_DIR :
                                     (p == 2) ? `GPAB_RST_C_DIR : `GPAB_RST_D_DIR;
            gpab_port #(.DIR_RESET(DIRR)) u_port (
                .ref_clk      (ref_clk),
                .rst          (rst),
                .imp_mask     (imp_mask[p*16 +: 16]),
                .wr_en        (wr_ok && (wr_off[6:5] == p)),
                .wr_slot      (wr_off[4:3]),
                .wr_data      (hwdata[15:0]),
                .pin_in       (pad_in[p*16 +: 16]),
                .pin_out      (pad_out[p*16 +: 16]),
                .pin_oe       (pad_oe[p*16 +: 16]),
                .direction    (dir_all[p*16 +: 16]),
                .output_latch (lat_all[p*16 +: 16]),
                .open_drain   (odc_all[p*16 +: 16]),
                .pin_state    (pin_all[p*16 +: 16])
            );
        end
    endgenerate
endmodule

// File: verif/gpab_board.sv
// gpab_board.sv: board model on the pad side of the gpio block
// assumes: pull-up on every pad; bench enables board drive only while the pad is an input
`timescale 1ns/100ps
module gpab_board (
    input  logic [63:0] pad_out,
    input  logic [63:0] pad_oe,
    input  logic [63:0] drive_en,
    input  logic [63:0] drive_val,
    output logic [63:0] pad_in
);
    // wire level: block drive wins, then board drive, else the pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & drive_en & drive_val) | (~pad_oe & ~drive_en);
endmodule

// File: verif/gpab_checker_assertions.sv
// gpab_checker_assertions.sv: pad and bus relations of the gpio top
// assumes: straps change only while rst is high
`timescale 1ns/100ps
module gpab_checker #(
    parameter PINS_100 = 1
) (
    input logic        ref_clk,
    input logic        rst,
    input logic        hsel,
    input logic        hwrite,
    input logic        hready,
    input logic        hreadyout,
    input logic        hresp,
    input logic        osc_output_function_bit,
    input logic [31:0] haddr,
    input logic [31:0] hwdata,
    input logic [31:0] hrdata,
    input logic [1:0]  htrans,
    input logic [1:0]  primary_osc_mode_field,
    input logic [2:0]  hsize,
    input logic [63:0] pad_in,
    input logic [63:0] pad_out,
    input logic [63:0] pad_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_upper_read_zero: assert property (hrdata[31:16] == 16'h0000) else $error("upper read half set");
    a_resp_okay: assert property (!hresp && hreadyout) else $error("bus response not okay");
    a_unmapped_read_zero: assert property (hsel && htrans[1] && !hwrite && hready && haddr > 32'h0000_0B78
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_gap_a_idle: assert property (pad_oe[13:11] == 3'h0 && !pad_oe[8]) else $error("port a gap driven");
    a_gap_c_idle: assert property (pad_oe[43:37] == 7'h00 && !pad_oe[32]) else $error("port c gap driven");
    a_small_no_a: assert property (PINS_100 == 0 |-> pad_oe[15:0] == 16'h0) else $error("port a driven");
    a_small_cut_bits: assert property (PINS_100 == 0 |-> pad_oe[36:33] == 4'h0 && pad_oe[63:60] == 4'h0)
        else $error("cut bits driven");
    a_osc_bits_off: assert property (primary_osc_mode_field[0] != primary_osc_mode_field[1]
        |-> !pad_oe[44] && !pad_oe[47]) else $error("osc bits driven");
    a_osc_func_off: assert property (!osc_output_function_bit |-> !pad_oe[47]) else $error("bit 15 driven");
    a_reset_inputs: assert property ($fell(rst) |-> pad_oe == 64'h0 ##1 pad_oe == 64'h0)
        else $error("drive after reset");
    c_write: cover property (hsel && htrans[1] && hwrite);
    c_read: cover property (hsel && htrans[1] && !hwrite);
    c_drive_b: cover property (pad_oe[31:16] != 16'h0);
endmodule

// File: verif/gpab_testbench.sv
// gpab_testbench.sv: directed tests of both pin variants over one ahb-lite master
// assumes: zero-wait slave; byte address 0x0B00 + port*32 + slot*8 (four times the register index)
`timescale 1ns/100ps
module testbench;
    logic        ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, osc_bit = 1'b1;
    logic [1:0]  htrans = 2'h0, osc_mode = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd_big, rd_small, rdata_big, rdata_small;
    logic [63:0] pad_in, pad_out, pad_oe, drv_en = 64'h0, drv_val = 64'h0;
    logic        hready;
    logic [15:0] big_mask[4] = '{16'hC6FF, 16'hFFFF, 16'hF01E, 16'hFFFF};
    logic [15:0] small_mask[4] = '{16'h0000, 16'hFFFF, 16'hF000, 16'h0FFF};
    int          n_errors = 0, n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    // big variant faces the board; small one only answers the bus
    gpab_top #(.PINS_100(1)) u_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(),
        .hrdata(rdata_big), .primary_osc_mode_field(osc_mode), .osc_output_function_bit(osc_bit),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
    gpab_top #(.PINS_100(0)) u_small (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(), .hresp(),
        .hrdata(rdata_small), .primary_osc_mode_field(osc_mode), .osc_output_function_bit(osc_bit),
        .pad_in(64'hFFFF_FFFF_FFFF_FFFF), .pad_out(), .pad_oe());
    gpab_board u_board (.pad_out(pad_out), .pad_oe(pad_oe), .drive_en(drv_en), .drive_val(drv_val), .pad_in(pad_in));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    function automatic logic [31:0] ra(input int port, input int slot);
        return 32'h0000_0B00 + 32'(port * 32 + slot * 8);
    endfunction
    // one single transfer; called just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [15:0] data);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, data};
        do @(posedge ref_clk); while (hready !== 1'b1);
        rd_big = rdata_big;
        rd_small = rdata_small;
    endtask
    task automatic do_reset(input logic [1:0] mode, input logic bit_on);
        rst <= 1'b1;
        osc_mode <= mode;
        osc_bit <= bit_on;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_reset_values;
        for (int p = 0; p < 4; p++) begin
            bus(1'b0, ra(p, 0), 16'h0000);
            check("direction 100", {16'h0, big_mask[p]}, rd_big);
            check("direction 64", {16'h0, small_mask[p]}, rd_small);
            bus(1'b0, ra(p, 3), 16'h0000);
            check("open drain", 32'h0, rd_big | rd_small);
        end
    endtask
    // all ones to every register but the pins slot: only implemented bits may stick
    task automatic t_unimplemented;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 4; s++) begin
                if (s != 1) begin
                    bus(1'b1, ra(p, s), 16'hFFFF);
                    bus(1'b0, ra(p, s), 16'h0000);
                    check("ones 100", {16'h0, big_mask[p]}, rd_big);
                    check("ones 64", {16'h0, small_mask[p]}, rd_small);
                end
            end
        end
        bus(1'b1, 32'h0000_0B80, 16'hFFFF);
        bus(1'b0, 32'h0000_0B80, 16'h0000);
        check("unmapped", 32'h0, rd_big | rd_small);
    endtask
    // port b: low byte open drain, then input from the board
    task automatic t_pin_drive;
        bus(1'b1, ra(1, 2), 16'hA5A5);
        bus(1'b1, ra(1, 3), 16'h00FF);
        bus(1'b1, ra(1, 0), 16'h0000);
        repeat (3) @(posedge ref_clk);
        check("enable b", 32'h0000_FF5A, {16'h0, pad_oe[31:16]});
        check("drive b", 32'h0000_A500, {16'h0, pad_out[31:16] & pad_oe[31:16]});
        bus(1'b0, ra(1, 1), 16'h0000);
        check("pins b out", 32'h0000_A5A5, rd_big);
        bus(1'b1, ra(1, 0), 16'hFFFF);
        drv_en <= 64'h0000_0000_FFFF_0000;
        drv_val <= 64'h0000_0000_3C3C_0000;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, ra(1, 1), 16'h0000);
        check("pins b in", 32'h0000_3C3C, rd_big);
        check("enable b off", 32'h0, {16'h0, pad_oe[31:16]});
    endtask
    task automatic t_osc_straps;
        logic [15:0] exp;
        for (int m = 0; m < 4; m++) begin
            for (int b = 0; b < 2; b++) begin
                do_reset(2'(m), 1'(b));
                exp = 16'hF01E;
                if (m == 1 || m == 2) exp = exp & 16'h6FFF;
                else if (b == 0) exp = exp & 16'h7FFF;
                bus(1'b0, ra(2, 0), 16'h0000);
                check("port c straps", {16'h0, exp}, rd_big);
                check("port c straps 64", {16'h0, exp & 16'hF000}, rd_small);
                // ports a, c and d all outputs: oscillator-owned and absent bits must still stay undriven
                for (int p = 0; p < 4; p++) begin
                    if (p != 1) begin
                        bus(1'b1, ra(p, 0), 16'h0000);
                    end
                end
                repeat (2) @(posedge ref_clk);
                check("port c drive", {16'h0, exp}, {16'h0, pad_oe[47:32]});
            end
        end
    endtask
    task automatic conclude;
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        do_reset(2'h0, 1'b1);
        t_reset_values();
        t_unimplemented();
        t_pin_drive();
        t_osc_straps();
        conclude();
    end
    // hang guard, well past the few hundred cycles used
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
bind gpab_top gpab_checker #(.PINS_100(PINS_100)) u_chk (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .haddr(haddr), .hwdata(hwdata),
    .hrdata(hrdata), .htrans(htrans), .primary_osc_mode_field(primary_osc_mode_field), .hsize(hsize),
    .osc_output_function_bit(osc_output_function_bit), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
